/* hw/wasc_pkg.sv */
// Purpose : Constants for the waveform auto-shutdown control block
// Assumes : APB slave, 32-bit data, one word per register
// Notes   : Offsets are byte addresses
package wasc_pkg;

    // ---------------------------------------------------------------
    // Register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] WASC_OFS_CTRL    = 8'h00;
    localparam logic [7:0] WASC_OFS_SRC_EN  = 8'h04;
    localparam logic [7:0] WASC_OFS_POL     = 8'h08;
    localparam logic [7:0] WASC_OFS_DB_RISE = 8'h0c;
    localparam logic [7:0] WASC_OFS_DB_FALL = 8'h10;
    localparam logic [7:0] WASC_OFS_IRQ_ST  = 8'h14;
    localparam logic [7:0] WASC_OFS_IRQ_MSK = 8'h18;

    // ---------------------------------------------------------------
    // Shutdown control field positions
    // ---------------------------------------------------------------
    localparam int WASC_BIT_SHUTDOWN = 7;
    localparam int WASC_BIT_RESTART  = 6;
    localparam int WASC_POS_BD_LVL   = 4;
    localparam int WASC_POS_AC_LVL   = 2;

    // ---------------------------------------------------------------
    // Shutdown level encodings
    // ---------------------------------------------------------------
    localparam logic [1:0] WASC_LVL_HIGH     = 2'h3;
    localparam logic [1:0] WASC_LVL_LOW      = 2'h2;
    localparam logic [1:0] WASC_LVL_TRISTATE = 2'h1;
    localparam logic [1:0] WASC_LVL_INACTIVE = 2'h0;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] WASC_RST_CTRL   = 8'h00;
    localparam logic [5:0] WASC_RST_SRC_EN = 6'h00;
    localparam logic [3:0] WASC_RST_POL    = 4'h0;
    localparam logic [5:0] WASC_RST_DB     = 6'h00;

    // ---------------------------------------------------------------
    // Output states
    // ---------------------------------------------------------------
    typedef enum logic [2:0]
    {
        WASC_RUN      = 3'b001,
        WASC_SHUT     = 3'b010,
        WASC_WAIT_RISE = 3'b100
    } wasc_state_type;

endpackage

/* hw/wasc_top.sv */
// Purpose : Auto-shutdown and restart control of a complementary waveform generator
// Assumes : Shutdown sources and data input synchronous to pclk
// Notes   : Outputs a..d with active-low output enables
//
// Overview of operation
// - Status bit 7 reads one while shutdown is in effect.
// - Bit 6 enables automatic restart; otherwise software clears status.
// - B/D shutdown level: 11 high, 10 low, 01 tri-state, 00 inactive.
// - A/C shutdown level field, same encoding, bits 3-2.
// - After status clears, hold shutdown levels until next data rising edge.
// - Six shutdown sources, each gated by its own enable bit.
// - Unimplemented bits, including control bits 1-0, read as zero.
//
// The APB register port and the placing of the registers were left to the implementer.
module wasc_top
#(
    parameter int NUM_SRC = 6
)
(
    // Clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Waveform side
    input  wire logic               wave_data,
    input  wire logic [3:0]         wave_drive,
    input  wire logic [NUM_SRC-1:0] shutdown_src,
    // Outputs a, b, c, d
    output logic      [3:0]         wave_out,
    output logic      [3:0]         wave_oe_n,
    // Interrupt
    output logic                    irq
);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    logic [7:0]         ctrl_ff;
    logic [NUM_SRC-1:0] src_en_ff;
    logic [3:0]         pol_ff;
    logic [5:0]         rise_deadband_ff;
    logic [5:0]         fall_deadband_ff;
    logic [1:0]         irq_st_ff;
    logic [1:0]         irq_msk_ff;
    logic               data_d_ff;
    logic [5:0]         db_cnt_ff;
    logic [3:0]         wave_out_ff;
    logic [3:0]         wave_oe_n_ff;
    wasc_pkg::wasc_state_type state_ff;
    wasc_pkg::wasc_state_type nxt_state;

    // ---------------------------------------------------------------
    // Bus decode
    // ---------------------------------------------------------------
    wire wr_en     = psel && penable && pwrite;
    wire rd_en     = psel && penable && !pwrite;
    wire sel_ctrl  = paddr == wasc_pkg::WASC_OFS_CTRL;
    wire sel_src   = paddr == wasc_pkg::WASC_OFS_SRC_EN;
    wire sel_pol   = paddr == wasc_pkg::WASC_OFS_POL;
    wire sel_dbr   = paddr == wasc_pkg::WASC_OFS_DB_RISE;
    wire sel_dbf   = paddr == wasc_pkg::WASC_OFS_DB_FALL;
    wire sel_ist   = paddr == wasc_pkg::WASC_OFS_IRQ_ST;
    wire sel_imsk  = paddr == wasc_pkg::WASC_OFS_IRQ_MSK;
    wire mapped    = sel_ctrl || sel_src || sel_pol || sel_dbr || sel_dbf
                     || sel_ist || sel_imsk;
    wire wr_ctrl   = wr_en && sel_ctrl;

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // ---------------------------------------------------------------
    // Shutdown detection
    // ---------------------------------------------------------------
    wire [NUM_SRC-1:0] src_hit = shutdown_src & src_en_ff;
    wire any_src     = |src_hit;
    wire auto_rst    = ctrl_ff[wasc_pkg::WASC_BIT_RESTART];
    // Software clear only lands while no source holds the event
    wire sw_clr      = wr_ctrl && !pwdata[wasc_pkg::WASC_BIT_SHUTDOWN];
    wire hw_clr      = auto_rst && !any_src;
    wire status      = ctrl_ff[wasc_pkg::WASC_BIT_SHUTDOWN];
    wire nxt_status  = any_src || (status && !(sw_clr || hw_clr));
    wire rise_edge   = wave_data && !data_d_ff;
    wire [1:0] lvl_bd = ctrl_ff[wasc_pkg::WASC_POS_BD_LVL +: 2];
    wire [1:0] lvl_ac = ctrl_ff[wasc_pkg::WASC_POS_AC_LVL +: 2];
    wire shut_evt    = any_src && !status;
    wire restart_evt = (state_ff == wasc_pkg::WASC_WAIT_RISE) && rise_edge;

    // ---------------------------------------------------------------
    // Output state machine
    // ---------------------------------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            wasc_pkg::WASC_RUN:
            begin
                if (nxt_status)
                    nxt_state = wasc_pkg::WASC_SHUT;
            end
            wasc_pkg::WASC_SHUT:
            begin
                if (!nxt_status)
                    nxt_state = wasc_pkg::WASC_WAIT_RISE;
            end
            wasc_pkg::WASC_WAIT_RISE:
            begin
                if (nxt_status)
                    nxt_state = wasc_pkg::WASC_SHUT;
                else if (rise_edge)
                    nxt_state = wasc_pkg::WASC_RUN;
            end
            default:
                nxt_state = wasc_pkg::WASC_SHUT;
        endcase
    end

    // Inactive level waits out the longer dead-band before it settles
    wire [5:0] db_max   = (rise_deadband_ff > fall_deadband_ff) ? rise_deadband_ff
                                                               : fall_deadband_ff;
    wire db_done        = db_cnt_ff == 6'h00;
    wire in_shut        = state_ff != wasc_pkg::WASC_RUN;

    // ---------------------------------------------------------------
    // Per-output drive selection
    // ---------------------------------------------------------------
    logic [3:0] nxt_out;
    logic [3:0] nxt_oe_n;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_out
            // Outputs a and c use the A/C field, b and d the B/D field
            wire [1:0] lvl = (gi == 0 || gi == 2) ? lvl_ac : lvl_bd;
            always_comb
            begin
                nxt_out[gi]  = wave_drive[gi] ^ pol_ff[gi];
                nxt_oe_n[gi] = 1'b0;
                if (in_shut)
                begin
                    unique case (lvl)
                        wasc_pkg::WASC_LVL_HIGH:     nxt_out[gi] = 1'b1;
                        wasc_pkg::WASC_LVL_LOW:      nxt_out[gi] = 1'b0;
                        wasc_pkg::WASC_LVL_TRISTATE:
                        begin
                            nxt_out[gi]  = 1'b0;
                            nxt_oe_n[gi] = 1'b1;
                        end
                        wasc_pkg::WASC_LVL_INACTIVE:
                        begin
                            // Until dead-band expires the previous level stands
                            nxt_out[gi] = db_done ? pol_ff[gi] : wave_out_ff[gi];
                        end
                    endcase
                end
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_ff          <= wasc_pkg::WASC_RST_CTRL;
            src_en_ff        <= '0;
            pol_ff           <= wasc_pkg::WASC_RST_POL;
            rise_deadband_ff <= wasc_pkg::WASC_RST_DB;
            fall_deadband_ff <= wasc_pkg::WASC_RST_DB;
            irq_msk_ff       <= 2'h0;
        end
        else
        begin
            ctrl_ff[wasc_pkg::WASC_BIT_SHUTDOWN] <= nxt_status;
            ctrl_ff[1:0] <= 2'h0;
            if (wr_ctrl)
                ctrl_ff[6:2] <= pwdata[6:2];
            if (wr_en && sel_src)
                src_en_ff <= pwdata[NUM_SRC-1:0];
            if (wr_en && sel_pol)
                pol_ff <= pwdata[3:0];
            if (wr_en && sel_dbr)
                rise_deadband_ff <= pwdata[5:0];
            if (wr_en && sel_dbf)
                fall_deadband_ff <= pwdata[5:0];
            if (wr_en && sel_imsk)
                irq_msk_ff <= pwdata[1:0];
        end
    end

    // Sticky events: set wins over write-one-to-clear
    wire [1:0] irq_set = {restart_evt, shut_evt};
    wire [1:0] irq_clr = (wr_en && sel_ist) ? pwdata[1:0] : 2'h0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_st_ff    <= 2'h0;
            state_ff     <= wasc_pkg::WASC_RUN;
            data_d_ff    <= 1'b0;
            db_cnt_ff    <= wasc_pkg::WASC_RST_DB;
            wave_out_ff  <= 4'h0;
            wave_oe_n_ff <= 4'h0;
        end
        else
        begin
            irq_st_ff    <= irq_set | (irq_st_ff & ~irq_clr);
            state_ff     <= nxt_state;
            data_d_ff    <= wave_data;
            db_cnt_ff    <= !in_shut ? db_max : (db_done ? db_cnt_ff : db_cnt_ff - 6'h01);
            wave_out_ff  <= nxt_out;
            wave_oe_n_ff <= nxt_oe_n;
        end
    end

    // ---------------------------------------------------------------
    // Read data and outputs
    // ---------------------------------------------------------------
    wire [31:0] rd_mux =
        sel_ctrl ? {24'h0, ctrl_ff[7:2], 2'h0} :
        sel_src  ? {{(32-NUM_SRC){1'b0}}, src_en_ff} :
        sel_pol  ? {28'h0, pol_ff} :
        sel_dbr  ? {26'h0, rise_deadband_ff} :
        sel_dbf  ? {26'h0, fall_deadband_ff} :
        sel_ist  ? {30'h0, irq_st_ff} :
        sel_imsk ? {30'h0, irq_msk_ff} : 32'h0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0;
        else if (psel && !penable && !pwrite)
            prdata <= rd_mux;
    end

    assign wave_out  = wave_out_ff;
    assign wave_oe_n = wave_oe_n_ff;
    assign irq       = |(irq_st_ff & irq_msk_ff);

endmodule

/* test/wasc_src_model.sv */
// Purpose : Far side: shutdown source lines and waveform data input
// Assumes : Commands from the bench, one pclk domain
// Notes   : Registered so every change lands just after an edge
module wasc_src_model
(
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Commands
    input  wire logic [5:0] src_cmd,
    input  wire logic       rise_cmd,
    // Toward the block
    output logic      [5:0] shutdown_src,
    output logic            wave_data
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            {shutdown_src, wave_data} <= 7'h00;
        else
            {shutdown_src, wave_data} <= {src_cmd, rise_cmd};
endmodule

/* test/wasc_top_bench.sv */
// Purpose : Self-checking bench for the auto-shutdown control block
// Assumes : Zero-wait APB, polarity 4'ha, normal drive 4'h6
// Notes   : Normal output is therefore 4'hc
module wasc_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        wave_data, irq, rise_cmd;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0]  wave_drive, wave_out, wave_oe_n, exp_o;
    logic [5:0]  shutdown_src, src_cmd;
    logic [1:0]  lv;
    int          mismatches, checked;

    wasc_top wasc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wave_data(wave_data), .wave_drive(wave_drive),
        .shutdown_src(shutdown_src), .wave_out(wave_out), .wave_oe_n(wave_oe_n), .irq(irq));
    wasc_src_model wasc_src_model_inst (.pclk(pclk), .presetn(presetn), .src_cmd(src_cmd),
        .rise_cmd(rise_cmd), .shutdown_src(shutdown_src), .wave_data(wave_data));

    task automatic test_done();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            mismatches++;
            test_done();
        end
        q = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e)
        begin
            mismatches++;
            $display("MISMATCH %0t register %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk_pin(input logic [3:0] g, input logic [3:0] e);
        checked++;
        if (g !== e)
        begin
            mismatches++;
            $display("MISMATCH %0t pins %h expected %h", $time, g, e);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk_reg(q, e);
    endtask

    // One-cycle data pulse, then room for the restart to land
    task automatic rise();
        rise_cmd <= 1'b1;
        @(posedge pclk);
        rise_cmd <= 1'b0;
        repeat (5) @(posedge pclk);
    endtask

    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    initial
    begin
        #(50 * 20000);
        mismatches++;
        test_done();
    end

    initial
    begin
        {presetn, psel, penable, pwrite, rise_cmd} = 5'h00;
        {paddr, pwdata, src_cmd} = 46'h0;
        wave_drive = 4'h6;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h00, 32'h0);
        rd(8'h1c, 32'h0);
        apb(1'b1, 8'h00, 32'hffffffff);
        rd(8'h00, 32'h7c);
        apb(1'b1, 8'h04, 32'h1);
        apb(1'b1, 8'h08, 32'ha);
        apb(1'b1, 8'h0c, 32'h2);
        apb(1'b1, 8'h10, 32'h3);
        apb(1'b1, 8'h18, 32'h1);
        for (int l = 3; l >= 0; l--)
        begin
            lv = l[1:0];
            exp_o = (lv == 2'h3) ? 4'hf : (lv == 2'h0) ? 4'ha : 4'h0;
            apb(1'b1, 8'h00, {26'h0, lv, lv, 2'h0});
            src_cmd <= 6'h01;
            repeat (8) @(posedge pclk);
            chk_pin(wave_out, exp_o);
            chk_pin(wave_oe_n, (lv == 2'h1) ? 4'hf : 4'h0);
            rd(8'h00, {24'h0, 2'h2, lv, lv, 2'h0});
            src_cmd <= 6'h00;
            apb(1'b1, 8'h00, {26'h0, lv, lv, 2'h0});
            repeat (3) @(posedge pclk);
            chk_pin(wave_out, exp_o);
            rise();
            chk_pin(wave_out, 4'hc);
        end
        chk_pin({3'h0, irq}, 4'h1);
        apb(1'b1, 8'h18, 32'h0);
        @(posedge pclk);
        chk_pin({3'h0, irq}, 4'h0);
        apb(1'b1, 8'h14, 32'h3);
        apb(1'b1, 8'h18, 32'h1);
        @(posedge pclk);
        chk_pin({3'h0, irq}, 4'h0);
        // Disabled sources only: nothing may trip
        src_cmd <= 6'h3e;
        repeat (8) @(posedge pclk);
        rd(8'h00, 32'h0);
        chk_pin(wave_out, 4'hc);
        src_cmd <= 6'h00;
        // Different levels per pair so a swapped field shows up
        apb(1'b1, 8'h00, 32'h6c);
        src_cmd <= 6'h01;
        repeat (8) @(posedge pclk);
        rd(8'h00, 32'hec);
        chk_pin(wave_out, 4'h5);
        src_cmd <= 6'h00;
        repeat (4) @(posedge pclk);
        rd(8'h00, 32'h6c);
        chk_pin(wave_out, 4'h5);
        rise();
        chk_pin(wave_out, 4'hc);
        test_done();
    end
endmodule

/* test/wasc_top_monitor.sv */
// Purpose : Port checker for the auto-shutdown control block
// Assumes : One pclk domain, APB slave with no wait states
// Notes   : Shadows the source enables from observed APB writes
module wasc_monitor
#(
    parameter int NUM_SRC = 6
)
(
    // Clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // APB
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    input  wire logic [31:0]        prdata,
    input  wire logic               pready,
    input  wire logic               pslverr,
    // Waveform side
    input  wire logic [NUM_SRC-1:0] shutdown_src,
    input  wire logic [3:0]         wave_out,
    input  wire logic [3:0]         wave_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [NUM_SRC-1:0] en_ff;
    wire  mapped   = (paddr <= wasc_pkg::WASC_OFS_IRQ_MSK) && (paddr[1:0] == 2'h0);
    wire  rd_setup = psel && !penable && !pwrite;
    wire  en_wr    = psel && penable && pwrite && (paddr == wasc_pkg::WASC_OFS_SRC_EN);

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            en_ff <= '0;
        else if (en_wr)
            en_ff <= pwdata[NUM_SRC-1:0];

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_ready; pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    property p_slverr; psel && penable && !mapped |-> pslverr; endproperty
    a_slverr: assert property (p_slverr) else $error("no error on unmapped");
    property p_noerr; psel && penable && mapped |-> !pslverr; endproperty
    a_noerr: assert property (p_noerr) else $error("error on mapped");
    property p_rd_unmapped; rd_setup && !mapped |=> prdata == 32'h0; endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped data");
    property p_rd_hi; rd_setup |=> prdata[31:8] == 24'h0; endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("upper bits set");
    property p_ctrl_low; rd_setup && paddr == 8'h00 |=> prdata[1:0] == 2'h0; endproperty
    a_ctrl_low: assert property (p_ctrl_low) else $error("control low bits set");
    property p_tri; (wave_out & wave_oe_n) == 4'h0; endproperty
    a_tri: assert property (p_tri) else $error("tri-stated pin driven");
    // Enabled source one edge earlier must show in a control read
    property p_status;
        $past(|(shutdown_src & en_ff)) && rd_setup && paddr == 8'h00 |=> prdata[7];
    endproperty
    a_status: assert property (p_status) else $error("status not set");
endmodule

bind wasc_top wasc_monitor #(.NUM_SRC(NUM_SRC)) wasc_monitor_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shutdown_src(shutdown_src), .wave_out(wave_out), .wave_oe_n(wave_oe_n));
